// file: hw/chip_mode_consts.svh
`ifndef CHIP_MODE_CONSTS_SVH
`define CHIP_MODE_CONSTS_SVH

// Register byte offsets on the Avalon-MM slave
`define CMS_OFS_MODE      5'h00
`define CMS_OFS_SECURITY  5'h04
`define CMS_OFS_CONTROL   5'h08
`define CMS_OFS_STATUS    5'h0c
`define CMS_OFS_CAUSE     5'h10

// Field positions
`define CMS_MODE_BIT       0
`define CMS_SEC_LSB        0
`define CMS_KEYEN_LSB      6
`define CMS_SECURED_BIT    8
`define CMS_CTL_CIS_BIT    0
`define CMS_CTL_PSTOP_BIT  1
`define CMS_CTL_FRZ_LSB    8
`define CMS_STS_HALT_BIT   2
`define CMS_STS_MODE_BIT   3

// Encodings and sizes
`define CMS_SEC_UNSECURED  2'b10
`define CMS_KEY_ENABLED    2'b10
`define CMS_KEY_BAD_LO     16'h0000
`define CMS_KEY_BAD_HI     16'hffff
`define CMS_NUM_KEYS       4
`define CMS_FREEZE_W       8
`define CMS_NUM_RST        5
`define CMS_RESET_VECTOR   24'hfffffc

// Reset values
`define CMS_CTL_RESET      1'b0
`define CMS_FREEZE_RESET   8'h00
`define CMS_SECREG_RESET   8'hff

`endif

// file: hw/chip_mode_pkg.sv
package chip_mode_pkg;

    // Power state, Gray coded along run -> wait and run -> stop paths
    typedef enum logic [1:0] {
        PWR_RUN   = 2'b00,
        PWR_WAIT  = 2'b01,
        PWR_PSTOP = 2'b11,
        PWR_STOP  = 2'b10
    } pwr_state_t;

    // Clock and power enables handed to the clock and power unit
    typedef struct packed {
        logic cpu_clk_en;
        logic bus_clk_en;
        logic periph_clk_en;
        logic osc_en;
        logic debug_serial_clk_en;
        logic regulator_full_perf;
        logic voltage_monitor_en;
        logic lowpower_periph_en;
    } clk_ctrl_t;

    // Access gates for the debug controller and flash command logic
    typedef struct packed {
        logic debug_ctrl_allowed;
        logic debug_mem_allowed;
        logic debug_erase_only;
        logic nvm_cmd_restricted;
    } access_t;

    // Reset sources: watchdog, clock monitor, pin, low voltage, power-on
    typedef struct packed {
        logic watchdog;
        logic clock_monitor;
        logic pin;
        logic low_voltage;
        logic power_on;
    } rst_src_t;

    // Entire state of the block
    typedef struct packed {
        logic [1:0]  mode_sync;
        logic [1:0]  nmi_sync;
        logic [1:0]  irq_sync;
        rst_src_t    rst_s1;
        rst_src_t    rst_s2;
        logic        in_reset;
        logic        mode;
        logic [7:0]  sec_reg;
        logic        secured;
        logic        halt;
        logic        clocks_in_stop;
        logic        pstop_sel;
        logic [7:0]  freeze_en;
        logic [7:0]  freeze;
        rst_src_t    cause;
        logic        rst_req;
        logic [23:0] rst_vector;
        pwr_state_t  pwr;
        clk_ctrl_t   clk;
        access_t     acc;
        logic        prog_sec_byte;
        logic        ack;
        logic [31:0] rdata;
    } state_t;

endpackage

// file: hw/chip_mode_security_control.sv
`timescale 1ns/1ps
`include "chip_mode_consts.svh"

module chip_mode_security_control (
    input  wire logic                            clk_sys_i,
    input  wire logic                            rst_i,
    // Avalon-MM slave
    input  wire logic [4:0]                      avs_address_i,
    input  wire logic                            avs_read_i,
    input  wire logic                            avs_write_i,
    input  wire logic [31:0]                     avs_writedata_i,
    input  wire logic [3:0]                      avs_byteenable_i,
    output logic [31:0]                          avs_readdata_o,
    output logic                                 avs_waitrequest_o,
    // Pins
    input  wire logic                            mode_select_level_i,
    input  wire logic                            nonmaskable_request_i,
    input  wire logic                            external_request_i,
    input  wire chip_mode_pkg::rst_src_t         reset_sources_i,
    // Clock and power unit
    input  wire logic                            oscillator_enable_i,
    input  wire logic [2:0]                      watchdog_rate_field_i,
    input  wire logic                            wait_instruction_i,
    input  wire logic                            stop_instruction_i,
    input  wire logic                            unmasked_interrupt_i,
    input  wire logic                            periodic_wakeup_timer_i,
    input  wire logic                            key_wakeup_i,
    input  wire logic                            rtc_wakeup_i,
    input  wire logic                            can_wakeup_i,
    input  wire logic                            real_time_tick_i,
    // Flash controller
    input  wire logic [7:0]                      nv_option_byte_i,
    input  wire logic [`CMS_NUM_KEYS*16-1:0]     backdoor_key_i,
    input  wire logic                            backdoor_match_i,
    input  wire logic                            erase_done_ok_i,
    // Debug controller
    input  wire logic                            debug_controller_enable_i,
    input  wire logic                            debug_halt_req_i,
    input  wire logic                            debug_go_i,
    // Outputs
    output logic                                 normal_single_chip_o,
    output logic                                 secured_o,
    output logic                                 debug_halt_state_o,
    output logic [`CMS_FREEZE_W-1:0]             freeze_o,
    output chip_mode_pkg::pwr_state_t            power_state_o,
    output chip_mode_pkg::clk_ctrl_t             clk_ctrl_o,
    output chip_mode_pkg::access_t               access_o,
    output logic                                 program_security_byte_o,
    output logic                                 reset_request_o,
    output logic [23:0]                          reset_vector_o,
    output chip_mode_pkg::rst_src_t              reset_cause_o
);
    import chip_mode_pkg::*;

    state_t s_q;
    state_t s_d;
    logic [`CMS_NUM_KEYS-1:0] key_ok;
    logic                     keys_valid;
    rst_src_t                 rst_en;
    logic                     stop_wake;
    logic                     wake_req;
    logic                     bus_req;

    // A key word of all zeros or all ones is an erased or blank cell
    function automatic logic key_word_valid(input logic [15:0] w);
        key_word_valid = (w != `CMS_KEY_BAD_LO) && (w != `CMS_KEY_BAD_HI);
    endfunction

    // Security field decode; only the single pattern unlocks
    function automatic logic field_secured(input logic [7:0] b);
        field_secured = (b[`CMS_SEC_LSB +: 2] != `CMS_SEC_UNSECURED);
    endfunction

    // Per-word key checks
    genvar gi;
    generate
        for (gi = 0; gi < `CMS_NUM_KEYS; gi = gi + 1) begin : g_key
            assign key_ok[gi] = key_word_valid(backdoor_key_i[gi*16 +: 16]);
        end
    endgenerate
    assign keys_valid = &key_ok;

    // Local enables of reset sources; both share one vector
    always_comb begin
        rst_en               = s_q.rst_s2;
        rst_en.clock_monitor = s_q.rst_s2.clock_monitor & oscillator_enable_i;
        rst_en.watchdog      = s_q.rst_s2.watchdog & (watchdog_rate_field_i != 3'h0);
    end

    // Wake sources; pins are read only after their second flop
    assign stop_wake = periodic_wakeup_timer_i | key_wakeup_i | rtc_wakeup_i | can_wakeup_i;
    assign wake_req  = s_q.nmi_sync[1] | s_q.irq_sync[1];
    assign bus_req   = (avs_read_i | avs_write_i) & ~s_q.ack;

    // Next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        // Synchronisers shift in and out of reset so sources seen during reset survive
        s_d.mode_sync = {s_q.mode_sync[0], mode_select_level_i};
        s_d.nmi_sync  = {s_q.nmi_sync[0], nonmaskable_request_i};
        s_d.irq_sync  = {s_q.irq_sync[0], external_request_i};
        s_d.rst_s1    = reset_sources_i;
        s_d.rst_s2    = s_q.rst_s1;
        s_d.prog_sec_byte = 1'b0;
        s_d.rst_req   = |rst_en;
        s_d.rst_vector = `CMS_RESET_VECTOR;
        // Cause capture: power-on starts a fresh record, set wins over clear
        if (rst_en.power_on) begin
            s_d.cause = rst_en;
        end else begin
            if (s_q.ack && avs_write_i && avs_address_i == `CMS_OFS_CAUSE && avs_byteenable_i[0]) begin
                s_d.cause = s_q.cause & ~rst_src_t'(avs_writedata_i[`CMS_NUM_RST-1:0]);
            end
            s_d.cause = s_d.cause | rst_en;
        end

        if (rst_i) begin
            // Reset: defaults; security held secured until the copy at release
            s_d.in_reset       = 1'b1;
            s_d.mode           = 1'b1;
            s_d.sec_reg        = `CMS_SECREG_RESET;
            s_d.secured        = 1'b1;
            s_d.halt           = 1'b0;
            s_d.clocks_in_stop = `CMS_CTL_RESET;
            s_d.pstop_sel      = `CMS_CTL_RESET;
            s_d.freeze_en      = `CMS_FREEZE_RESET;
            s_d.pwr            = PWR_RUN;
            s_d.ack            = 1'b0;
            s_d.rdata          = 32'h0;
        end else begin
            s_d.in_reset = 1'b0;
            if (s_q.in_reset) begin
                // First cycle after release: catch the strap and the option byte
                s_d.mode    = s_q.mode_sync[1];
                s_d.sec_reg = nv_option_byte_i;
                s_d.secured = field_secured(nv_option_byte_i);
                s_d.halt    = ~s_q.mode_sync[1];
            end else begin
                // Debug halt requests; a request wins over a go in the same cycle
                if (debug_go_i) begin
                    s_d.halt = 1'b0;
                end
                if (debug_halt_req_i && debug_controller_enable_i && s_q.acc.debug_ctrl_allowed) begin
                    s_d.halt = 1'b1;
                end
                // Backdoor unlock lasts until the next reset
                if (backdoor_match_i && s_q.mode && keys_valid &&
                    s_q.sec_reg[`CMS_KEYEN_LSB +: 2] == `CMS_KEY_ENABLED) begin
                    s_d.secured = 1'b0;
                end
                // Full erase leaves the part unsecured and rewrites the byte
                if (erase_done_ok_i) begin
                    s_d.secured = 1'b0;
                    s_d.sec_reg[`CMS_SEC_LSB +: 2] = `CMS_SEC_UNSECURED;
                    s_d.prog_sec_byte = 1'b1;
                end
            end

            // Register writes, taken on the edge where waitrequest is low
            if (s_q.ack && avs_write_i) begin
                case (avs_address_i)
                    `CMS_OFS_MODE: begin
                        // Only special to normal; the reverse would reopen debug access
                        if (avs_byteenable_i[0] && avs_writedata_i[`CMS_MODE_BIT] && !s_q.mode) begin
                            s_d.mode = 1'b1;
                        end
                    end
                    `CMS_OFS_CONTROL: begin
                        if (avs_byteenable_i[0]) begin
                            s_d.clocks_in_stop = avs_writedata_i[`CMS_CTL_CIS_BIT];
                            s_d.pstop_sel      = avs_writedata_i[`CMS_CTL_PSTOP_BIT];
                        end
                        if (avs_byteenable_i[1]) begin
                            s_d.freeze_en = avs_writedata_i[`CMS_CTL_FRZ_LSB +: 8];
                        end
                    end
                    default: begin
                        s_d.mode = s_d.mode;
                    end
                endcase
            end

            // Power state machine
            case (s_q.pwr)
                PWR_RUN: begin
                    if (wait_instruction_i) begin
                        s_d.pwr = PWR_WAIT;
                    end else if (stop_instruction_i) begin
                        s_d.pwr = s_q.pstop_sel ? PWR_PSTOP : PWR_STOP;
                    end
                end
                PWR_WAIT: begin
                    if (wake_req || unmasked_interrupt_i) begin
                        s_d.pwr = PWR_RUN;
                    end
                end
                PWR_PSTOP: begin
                    if (wake_req || stop_wake || real_time_tick_i) begin
                        s_d.pwr = PWR_RUN;
                    end
                end
                PWR_STOP: begin
                    if (wake_req || stop_wake) begin
                        s_d.pwr = PWR_RUN;
                    end
                end
                default: begin
                    s_d.pwr = PWR_RUN;
                end
            endcase

            // Read data prepared one cycle ahead of the answer
            s_d.ack = bus_req;
            if (bus_req && avs_read_i) begin
                case (avs_address_i)
                    `CMS_OFS_MODE:     s_d.rdata = {31'h0, s_q.mode};
                    `CMS_OFS_SECURITY: s_d.rdata = {23'h0, s_q.secured, s_q.sec_reg};
                    `CMS_OFS_CONTROL:  s_d.rdata = {16'h0, s_q.freeze_en, 6'h0, s_q.pstop_sel, s_q.clocks_in_stop};
                    `CMS_OFS_STATUS:   s_d.rdata = {28'h0, s_q.mode, s_q.halt, s_q.pwr};
                    `CMS_OFS_CAUSE:    s_d.rdata = {27'h0, s_q.cause};
                    default:           s_d.rdata = 32'h0;
                endcase
            end
        end

        // Freeze follows debug halt per module enable
        s_d.freeze = s_d.freeze_en & {`CMS_FREEZE_W{s_d.halt}};

        // Access gates from mode and secured state
        s_d.acc.debug_ctrl_allowed = ~(s_d.mode & s_d.secured);
        s_d.acc.debug_mem_allowed  = ~s_d.secured;
        s_d.acc.debug_erase_only   = ~s_d.mode & s_d.secured;
        s_d.acc.nvm_cmd_restricted = s_d.secured;

        // Clock and power enables for the next state
        s_d.clk.cpu_clk_en          = 1'b1;
        s_d.clk.bus_clk_en          = 1'b1;
        s_d.clk.periph_clk_en       = 1'b1;
        s_d.clk.osc_en              = 1'b1;
        s_d.clk.debug_serial_clk_en = debug_controller_enable_i;
        s_d.clk.regulator_full_perf = 1'b1;
        s_d.clk.voltage_monitor_en  = 1'b1;
        s_d.clk.lowpower_periph_en  = 1'b1;
        case (s_d.pwr)
            PWR_WAIT: begin
                s_d.clk.cpu_clk_en = 1'b0;
            end
            PWR_PSTOP: begin
                // Oscillator kept so wakeup is fast; low-power timers stay on, regulator and voltage monitor only with debug enabled
                s_d.clk.cpu_clk_en          = 1'b0;
                s_d.clk.bus_clk_en          = 1'b0;
                s_d.clk.periph_clk_en       = 1'b0;
                s_d.clk.regulator_full_perf = debug_controller_enable_i;
                s_d.clk.voltage_monitor_en  = debug_controller_enable_i;
            end
            PWR_STOP: begin
                if (debug_controller_enable_i) begin
                    s_d.clk.cpu_clk_en    = s_q.clocks_in_stop;
                    s_d.clk.bus_clk_en    = s_q.clocks_in_stop;
                    s_d.clk.periph_clk_en = s_q.clocks_in_stop;
                    s_d.clk.lowpower_periph_en = s_q.clocks_in_stop;
                    s_d.clk.osc_en        = 1'b1;
                end else begin
                    s_d.clk.cpu_clk_en          = 1'b0;
                    s_d.clk.bus_clk_en          = 1'b0;
                    s_d.clk.periph_clk_en       = 1'b0;
                    s_d.clk.osc_en              = 1'b0;
                    s_d.clk.lowpower_periph_en  = 1'b0;
                    s_d.clk.regulator_full_perf = 1'b0;
                    s_d.clk.voltage_monitor_en  = 1'b0;
                end
            end
            default: begin
                s_d.clk.cpu_clk_en = 1'b1;
            end
        endcase
    end

    // One register for all state
    always_ff @(posedge clk_sys_i) begin
        s_q <= s_d;
    end

    // Outputs straight from flops
    assign avs_readdata_o          = s_q.rdata;
    assign avs_waitrequest_o       = ~s_q.ack;
    assign normal_single_chip_o    = s_q.mode;
    assign secured_o               = s_q.secured;
    assign debug_halt_state_o      = s_q.halt;
    assign freeze_o                = s_q.freeze;
    assign power_state_o           = s_q.pwr;
    assign clk_ctrl_o              = s_q.clk;
    assign access_o                = s_q.acc;
    assign program_security_byte_o = s_q.prog_sec_byte;
    assign reset_request_o         = s_q.rst_req;
    assign reset_vector_o          = s_q.rst_vector;
    assign reset_cause_o           = s_q.cause;

endmodule

// file: testbench/flash_ctrl_model.sv
`timescale 1ns/1ps
// Flash side: keeps the option byte image and answers each command one clock later
module flash_ctrl_model (
    input  wire logic       clk_sys_i,
    input  wire logic       store_i,
    input  wire logic [7:0] byte_i,
    input  wire logic       match_cmd_i,
    input  wire logic       erase_cmd_i,
    input  wire logic       program_i,
    output logic [7:0]      nv_option_byte_o,
    output logic            backdoor_match_o,
    output logic            erase_done_ok_o
);
    // A completed full erase leaves the unsecured pattern in the byte
    always_ff @(posedge clk_sys_i) begin
        if (store_i)
            nv_option_byte_o <= byte_i;
        else if (program_i)
            nv_option_byte_o[1:0] <= 2'b10;
        backdoor_match_o <= match_cmd_i;
        erase_done_ok_o  <= erase_cmd_i;
    end
endmodule

// file: testbench/chip_mode_security_control_chk.sv
`timescale 1ns/1ps
module chip_mode_security_control_chk
    import chip_mode_pkg::*;
(
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    input wire logic       unmasked_interrupt_i,
    input wire logic       backdoor_match_i,
    input wire logic       erase_done_ok_i,
    input wire logic       debug_controller_enable_i,
    input wire logic       normal_single_chip_o,
    input wire logic       secured_o,
    input wire logic       debug_halt_state_o,
    input wire logic [7:0] freeze_o,
    input wire pwr_state_t power_state_o,
    input wire clk_ctrl_t  clk_ctrl_o,
    input wire access_t    access_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Security and mode gates update in the same register as their causes; the checks still wait a cycle
    a_halt_on_entry: assert property ($past(rst_i) |=> debug_halt_state_o == !normal_single_chip_o)
        else $error("halt after reset does not follow mode");
    a_freeze_gate: assert property (!debug_halt_state_o && !$past(debug_halt_state_o) |-> freeze_o == 8'h00)
        else $error("freeze without halt");
    a_wait_cpu_off: assert property (power_state_o == PWR_WAIT && $past(power_state_o) == PWR_WAIT
        |-> !clk_ctrl_o.cpu_clk_en && clk_ctrl_o.periph_clk_en) else $error("wait clocks wrong");
    a_wait_wake: assert property (power_state_o == PWR_WAIT && unmasked_interrupt_i
        |-> ##[1:4] power_state_o == PWR_RUN) else $error("wait not left");
    a_stop_debug_on: assert property (power_state_o == PWR_STOP && $past(power_state_o) == PWR_STOP
        && debug_controller_enable_i && $past(debug_controller_enable_i) |-> clk_ctrl_o.regulator_full_perf
        && clk_ctrl_o.voltage_monitor_en && clk_ctrl_o.debug_serial_clk_en) else $error("stop debug power");
    a_stop_quiet: assert property (power_state_o == PWR_STOP && $past(power_state_o) == PWR_STOP
        && !debug_controller_enable_i && !$past(debug_controller_enable_i)
        |-> !clk_ctrl_o.cpu_clk_en && !clk_ctrl_o.osc_en) else $error("stop clocks running");
    a_secure_normal: assert property (!$past(rst_i) && $past(secured_o && normal_single_chip_o) && secured_o
        && normal_single_chip_o |-> !access_o.debug_ctrl_allowed && access_o.nvm_cmd_restricted)
        else $error("secured normal gate open");
    a_secure_special: assert property (!$past(rst_i) && $past(secured_o && !normal_single_chip_o) && secured_o
        && !normal_single_chip_o |-> !access_o.debug_mem_allowed && access_o.debug_erase_only)
        else $error("secured special gate open");
    a_secured_cause: assert property (!$stable(secured_o)
        |-> $past(rst_i, 2) || $past(backdoor_match_i) || $past(erase_done_ok_i))
        else $error("secured changed without cause");
    c_wait_wake: cover property (power_state_o == PWR_WAIT ##1 power_state_o == PWR_RUN);
    c_stop_debug: cover property (power_state_o == PWR_STOP && debug_controller_enable_i);
    c_unlock: cover property ($fell(secured_o) && normal_single_chip_o);
endmodule
bind chip_mode_security_control chip_mode_security_control_chk u_chk (.*);

// file: testbench/tb_chip_mode_security_control.sv
`timescale 1ns/1ps
module tb_chip_mode_security_control;
    import chip_mode_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic [4:0]  adr       = 5'h00;
    logic        rd        = 1'b0;
    logic        wr        = 1'b0;
    logic [31:0] wdat      = 32'h0;
    logic        mode_sel  = 1'b1;
    logic        osc_en    = 1'b1;
    logic        dbg_en    = 1'b0;
    logic [2:0]  rate      = 3'h1;
    logic [7:0]  wk        = 8'h00;
    logic [7:0]  nvb       = 8'hff;
    logic [6:0]  evt       = 7'h00;
    logic [4:0]  src       = 5'h00;
    logic [63:0] keys      = 64'h1;
    logic [31:0] rdat, q;
    logic [7:0]  opt, frz, fz, b;
    logic [63:0] k;
    logic        wreq, match, erase_ok, prog, nsc, sec, halt, rreq, exp_s;
    pwr_state_t  pwr;
    clk_ctrl_t   ck;
    access_t     acc;
    logic [23:0] vec;
    rst_src_t    cause;
    int          fail_count = 0;
    int          num_checks = 0;
    // Per stop case: wake source, control bits, checked clock enables and their values
    int          wsrc [5] = '{7, 4, 3, 5, 6};
    logic [1:0]  ctl [5]  = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h0};
    logic [7:0]  msk [5]  = '{8'hd1, 8'hf0, 8'hce, 8'hce, 8'hf0};
    logic [7:0]  ckx [5]  = '{8'h11, 8'h00, 8'hce, 8'h0e, 8'h00};

    always #2.5 clk_sys_i = ~clk_sys_i;

    chip_mode_security_control u_chip_mode_security_control (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .mode_select_level_i(mode_sel), .nonmaskable_request_i(wk[0]), .external_request_i(wk[1]),
        .reset_sources_i(src), .oscillator_enable_i(osc_en), .watchdog_rate_field_i(rate),
        .wait_instruction_i(evt[0]), .stop_instruction_i(evt[1]), .unmasked_interrupt_i(wk[2]),
        .periodic_wakeup_timer_i(wk[3]), .key_wakeup_i(wk[4]), .rtc_wakeup_i(wk[5]), .can_wakeup_i(wk[6]),
        .real_time_tick_i(wk[7]), .nv_option_byte_i(opt), .backdoor_key_i(keys), .backdoor_match_i(match),
        .erase_done_ok_i(erase_ok), .debug_controller_enable_i(dbg_en), .debug_halt_req_i(evt[2]),
        .debug_go_i(evt[3]), .normal_single_chip_o(nsc), .secured_o(sec), .debug_halt_state_o(halt),
        .freeze_o(frz), .power_state_o(pwr), .clk_ctrl_o(ck), .access_o(acc), .program_security_byte_o(prog),
        .reset_request_o(rreq), .reset_vector_o(vec), .reset_cause_o(cause));
    flash_ctrl_model u_flash_ctrl_model (.clk_sys_i(clk_sys_i), .store_i(evt[4]), .byte_i(nvb),
        .match_cmd_i(evt[5]), .erase_cmd_i(evt[6]), .program_i(prog), .nv_option_byte_o(opt),
        .backdoor_match_o(match), .erase_done_ok_o(erase_ok));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic pulse(input int i);
        evt[i] <= 1'b1;
        step(1);
        evt[i] <= 1'b0;
    endtask
    // Holds the request until waitrequest is sampled low, then releases it
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int          n;
        logic        ws;
        logic [31:0] rs;
        n = 0;
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        // Look mid-cycle so the values are those standing at the next rising edge
        do begin
            @(negedge clk_sys_i);
            ws = wreq;
            rs = rdat;
            step(1);
            n++;
        end while (ws !== 1'b0 && n < 50);
        q = rs;
        if (n >= 50)
            fail_count++;
        rd <= 1'b0;
        wr <= 1'b0;
        step(1);
    endtask
    task automatic do_reset(input logic s, input logic [7:0] by);
        mode_sel <= s;
        nvb <= by;
        pulse(4);
        rst_i <= 1'b1;
        step(6);
        rst_i <= 1'b0;
        step(2);
    endtask
    function automatic logic unlock_ok(input logic m, input logic [1:0] ke, input logic [63:0] kk);
        unlock_ok = m && ke == 2'b10;
        for (int w = 0; w < 4; w++)
            unlock_ok &= kk[w*16 +: 16] != 16'h0000 && kk[w*16 +: 16] != 16'hffff;
    endfunction
    task automatic report_and_stop();
        if (fail_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 5000 cycles
    initial begin
        step(5000);
        fail_count++;
        report_and_stop();
    end

    initial begin
        void'($urandom(330));
        // Every strap level against every security pattern; new byte waits for reset
        for (int i = 0; i < 8; i++) begin
            b = {6'($urandom()), 2'(i)};
            nvb <= b;
            pulse(4);
            step(2);
            if (i > 0)
                check(sec, exp_s);
            do_reset(i[2], b);
            exp_s = b[1:0] != 2'b10;
            check(nsc, i[2]);
            check(halt, !i[2]);
            check(sec, exp_s);
            bus(1'b0, 5'h04, 32'h0);
            check(q[8:0], {exp_s, b});
            if (exp_s && i[2])
                check({acc.debug_ctrl_allowed, acc.debug_mem_allowed, acc.nvm_cmd_restricted}, 3'b001);
            if (exp_s && !i[2])
                check({acc.debug_mem_allowed, acc.debug_erase_only}, 2'b01);
        end
        // Backdoor unlock: good keys, key access off, zero word, all-ones word, special mode
        for (int j = 0; j < 5; j++) begin
            for (int w = 0; w < 4; w++)
                k[w*16 +: 16] = 16'($urandom_range(65534, 1));
            if (j == 2)
                k[15:0] = 16'h0000;
            if (j == 3)
                k[47:32] = 16'hffff;
            keys <= k;
            do_reset(j != 4, {(j == 1) ? 2'b01 : 2'b10, 4'h0, 2'b01});
            pulse(5);
            step(3);
            check(sec, !unlock_ok(j != 4, (j == 1) ? 2'b01 : 2'b10, k));
        end
        bus(1'b1, 5'h00, 32'h0);
        bus(1'b0, 5'h00, 32'h0);
        check(q[0], 1'b0);
        bus(1'b1, 5'h00, 32'h1);
        bus(1'b1, 5'h00, 32'h0);
        bus(1'b0, 5'h00, 32'h0);
        check(q[0], 1'b1);
        bus(1'b0, 5'h14, 32'h0);
        check(q, 32'h0);
        pulse(6);
        step(4);
        check(sec, 1'b0);
        check(opt[1:0], 2'b10);
        dbg_en <= 1'b1;
        fz = 8'($urandom());
        bus(1'b1, 5'h08, {16'h0, fz, 8'h00});
        pulse(2);
        step(2);
        check(frz, fz);
        pulse(3);
        step(2);
        check(frz, 8'h00);
        for (int w = 0; w < 3; w++) begin
            pulse(0);
            step(3);
            check(pwr, PWR_WAIT);
            check({ck.cpu_clk_en, ck.periph_clk_en}, 2'b01);
            wk[w] <= 1'b1;
            step(6);
            check(pwr, PWR_RUN);
            wk[w] <= 1'b0;
            step(4);
        end
        // Control is set up before stop is entered, never while stopped
        for (int c = 0; c < 5; c++) begin
            dbg_en <= c == 2 || c == 3;
            bus(1'b1, 5'h08, {30'h0, ctl[c]});
            pulse(1);
            step(3);
            check(pwr, c == 0 ? PWR_PSTOP : PWR_STOP);
            check(ck & msk[c], ckx[c]);
            wk[wsrc[c]] <= 1'b1;
            step(6);
            check(pwr, PWR_RUN);
            wk[wsrc[c]] <= 1'b0;
            step(4);
        end
        // Each reset source, then clock monitor and watchdog with their local enables off
        for (int r = 0; r < 7; r++) begin
            osc_en <= r != 5;
            rate <= (r == 6) ? 3'h0 : 3'h1;
            src <= (r < 5) ? 5'(1 << r) : ((r == 5) ? 5'h08 : 5'h10);
            step(5);
            check(rreq, r < 5);
            check(vec, 24'hfffffc);
            src <= 5'h00;
            step(5);
        end
        check(cause, 5'h1f);
        report_and_stop();
    end
endmodule
